// ---- design/cfg_pkg.sv ----
// configuration byte decoder package: field layout, defaults, timing counts
// assumes nothing beyond a single 125 MHz clock domain
package cfg_pkg;

    // byte 0 field positions
    localparam int B0_HALT_WDG_RST = 7;
    localparam int B0_WDG_TYPE = 6;
    localparam int B0_RSVD_HI = 5;
    localparam int B0_RSVD_LO = 1;
    localparam int B0_RDP = 0;
    // byte 1 field positions
    localparam int B1_PKG = 7;
    localparam int B1_RST_DLY = 6;
    localparam int B1_CLK_SRC_HI = 5;
    localparam int B1_CLK_SRC_LO = 4;
    localparam int B1_RANGE_HI = 3;
    localparam int B1_RANGE_LO = 1;
    localparam int B1_DBL_OFF = 0;

    // erased flash reads as all ones
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // shipped defaults
    localparam logic [7:0] DEFAULT_BYTE0 = 8'he7;
    localparam logic [7:0] DEFAULT_BYTE1 = 8'h6f;

    // processor cycles of reset phase / halt-exit delay
    localparam logic [12:0] DELAY_LONG = 13'h1000;
    localparam logic [12:0] DELAY_SHORT = 13'h0100;

    // clock source codes
    localparam logic [1:0] SRC_RESONATOR = 2'h0;
    localparam logic [1:0] SRC_RESERVED = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h3;

    // range codes
    localparam logic [2:0] RANGE_1_2 = 3'h0;
    localparam logic [2:0] RANGE_2_4 = 3'h1;
    localparam logic [2:0] RANGE_4_8 = 3'h2;
    localparam logic [2:0] RANGE_8_16 = 3'h3;

    // pads per port
    localparam int PADS_PER_PORT = 8;

    // register map over the bus
    localparam logic [11:0] ADDR_BYTES = 12'h000;
    localparam logic [11:0] ADDR_DECODE = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_CTRL = 12'h00c;
    localparam int CTRL_PROG_MODE = 0;
    localparam int CTRL_ERASE = 1;
    localparam int CTRL_WRITE = 2;

    typedef struct packed {
        logic halt_watchdog_reset_sel;
        logic watchdog_type_sel;
        logic readout_protect;
        logic package_sel;
        logic reset_delay_sel;
        logic [1:0] clock_source_type;
        logic [2:0] osc_range_sel;
        logic freq_doubler_off;
    } cfg_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WIPE = 4'b0010,
        ST_ERASE = 4'b0100,
        ST_DONE = 4'b1000
    } erase_e;

endpackage : cfg_pkg

// ---- design/cfg_decode.sv ----
// decodes two raw configuration bytes into named settings
// assumes the bytes are already held stable by the caller
`timescale 1ns/100ps
module cfg_decode (
    input wire logic [7:0] i_byte0, // first configuration byte
    input wire logic [7:0] i_byte1, // second configuration byte
    output cfg_pkg::cfg_s o_cfg, // decoded fields
    output logic [12:0] o_delay, // reset / halt-exit cycles
    output logic o_src_reserved, // reserved source code chosen
    output logic o_is_resonator // resonator source chosen
);
    always_comb begin
        o_cfg.halt_watchdog_reset_sel = i_byte0[cfg_pkg::B0_HALT_WDG_RST];
        o_cfg.watchdog_type_sel = i_byte0[cfg_pkg::B0_WDG_TYPE];
        o_cfg.readout_protect = i_byte0[cfg_pkg::B0_RDP];
        o_cfg.package_sel = i_byte1[cfg_pkg::B1_PKG];
        o_cfg.reset_delay_sel = i_byte1[cfg_pkg::B1_RST_DLY];
        o_cfg.clock_source_type =
            i_byte1[cfg_pkg::B1_CLK_SRC_HI:cfg_pkg::B1_CLK_SRC_LO];
        o_cfg.osc_range_sel =
            i_byte1[cfg_pkg::B1_RANGE_HI:cfg_pkg::B1_RANGE_LO];
        o_cfg.freq_doubler_off = i_byte1[cfg_pkg::B1_DBL_OFF];
    end

    assign o_delay = i_byte1[cfg_pkg::B1_RST_DLY] ? cfg_pkg::DELAY_SHORT
                                                  : cfg_pkg::DELAY_LONG;
    assign o_is_resonator = (o_cfg.clock_source_type == cfg_pkg::SRC_RESONATOR);
    assign o_src_reserved = (o_cfg.clock_source_type == cfg_pkg::SRC_RESERVED)
        || (o_cfg.clock_source_type == 2'h2);
endmodule : cfg_decode

// ---- design/option_byte_config_decode.sv ----
// configuration byte store, loader and decoder behind an AHB-Lite slave
// assumes one clock, synchronous active-low reset, pins on same clock
// Contract
// - byte0 bit7 set makes halt entry with an active watchdog reset the chip.
// - byte0 bit6 clear gives an always-on watchdog, set a software-enabled one.
// - byte0 bit0 clear turns on read-out and flash-write protection.
// - erasing the bytes while protected first wipes all user memory.
// - byte1 bit7 clear means the 32-pin package, set the 42/44-pin one.
// - unbonded pads leave reset as pulled-up inputs and software keeps them so.
// - byte1 bit6 gives 4096 cycles of reset and halt-exit delay when clear, 256 when set.
// - byte1 bits 5:4 choose resonator (00), reserved (01) or external source; the code flags 10 as reserved too, so only 11 is external.
// - byte1 bits 3:1 choose the 1-2, 2-4, 4-8 or 8-16 MHz range.
// - the bytes are reachable only in programming mode and erase to ff.
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
module option_byte_config_decode (
    input wire logic i_mclk, // 125 MHz clock
    input wire logic i_rstn, // synchronous reset, active low
    input wire logic i_hsel, // slave select
    input wire logic [11:0] i_haddr, // byte address
    input wire logic [1:0] i_htrans, // transfer type
    input wire logic i_hwrite, // write strobe
    input wire logic [2:0] i_hsize, // transfer size
    input wire logic [31:0] i_hwdata, // write data
    input wire logic i_hready, // bus ready in
    input wire logic i_halt_entry, // core enters halt mode
    input wire logic i_watchdog_active, // watchdog running
    input wire logic [2:0] i_unbonded_port, // ports with unbonded pads
    output logic [31:0] o_hrdata, // read data
    output logic o_hreadyout, // slave ready
    output logic o_hresp, // response, always okay
    output cfg_pkg::cfg_s o_cfg, // held decoded settings
    output logic [12:0] o_reset_delay, // reset/halt-exit cycles
    output logic o_halt_reset_req, // reset request on halt entry
    output logic o_watchdog_hw_on, // watchdog forced on
    output logic o_protect_on, // read-out protection active
    output logic o_flash_write_block, // flash write blocked
    output logic o_user_mem_wipe, // user memory wipe strobe
    output logic o_pad_pullup_lock, // pull-ups held on unbonded pads
    output logic o_doubler_on, // frequency doubler enabled
    output logic o_src_reserved // reserved clock source code
);
    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [7:0] nv_byte0 = cfg_pkg::DEFAULT_BYTE0;
    logic [7:0] nv_byte1 = cfg_pkg::DEFAULT_BYTE1;
    logic prog_mode;
    logic [2:0] ctrl;
    cfg_pkg::erase_e state;
    cfg_pkg::cfg_s dec_cfg;
    logic [12:0] dec_delay;
    logic dec_src_res;
    logic dec_is_res;
    logic in_reset;

    // ------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------
    logic ap_valid;
    logic dp_write;
    logic dp_read;
    logic [11:0] dp_addr;

    assign ap_valid = i_hsel && i_hready && i_htrans[1];

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 12'h000;
        end else begin
            dp_write <= ap_valid && i_hwrite;
            dp_read <= ap_valid && !i_hwrite;
            if (ap_valid) begin
                dp_addr <= i_haddr;
            end
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    // ------------------------------------------------------------
    // control register and programming mode
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_bytes;
    assign wr_ctrl = dp_write && (dp_addr == cfg_pkg::ADDR_CTRL);
    assign wr_bytes = dp_write && (dp_addr == cfg_pkg::ADDR_BYTES);

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            prog_mode <= 1'b0;
        end else if (wr_ctrl) begin
            prog_mode <= i_hwdata[cfg_pkg::CTRL_PROG_MODE];
        end
    end

    // ------------------------------------------------------------
    // erase sequence: wipe user memory first when protected
    // ------------------------------------------------------------
    logic erase_req;
    assign erase_req = wr_ctrl && prog_mode
        && i_hwdata[cfg_pkg::CTRL_ERASE];

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state <= cfg_pkg::ST_IDLE;
        end else begin
            case (state)
                cfg_pkg::ST_IDLE: begin
                    if (erase_req) begin
                        state <= nv_byte0[cfg_pkg::B0_RDP]
                            ? cfg_pkg::ST_ERASE : cfg_pkg::ST_WIPE;
                    end
                end
                cfg_pkg::ST_WIPE: state <= cfg_pkg::ST_ERASE;
                cfg_pkg::ST_ERASE: state <= cfg_pkg::ST_DONE;
                cfg_pkg::ST_DONE: state <= cfg_pkg::ST_IDLE;
                default: state <= cfg_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_user_mem_wipe <= 1'b0;
        end else begin
            o_user_mem_wipe <= (state == cfg_pkg::ST_WIPE);
        end
    end

    // ------------------------------------------------------------
    // non-volatile bytes, written only in programming mode
    // ------------------------------------------------------------
    // no reset: the bytes are non-volatile and must survive it, else a
    // programmed setting could never be sampled; power-up is the default
    always_ff @(posedge i_mclk) begin
        if (state == cfg_pkg::ST_ERASE) begin
            nv_byte0 <= cfg_pkg::ERASED_BYTE;
            nv_byte1 <= cfg_pkg::ERASED_BYTE;
        end else if (wr_bytes && prog_mode && state == cfg_pkg::ST_IDLE) begin
            nv_byte0 <= i_hwdata[7:0];
            nv_byte1 <= i_hwdata[15:8];
        end
    end

    // ------------------------------------------------------------
    // decode and capture on the first edge after reset release
    // ------------------------------------------------------------
    cfg_decode u_dec (
        .i_byte0(nv_byte0),
        .i_byte1(nv_byte1),
        .o_cfg(dec_cfg),
        .o_delay(dec_delay),
        .o_src_reserved(dec_src_res),
        .o_is_resonator(dec_is_res)
    );

    // capture on the first edge after release so the defaults are seen
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            in_reset <= 1'b1;
        end else begin
            in_reset <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_cfg <= '0;
            o_reset_delay <= cfg_pkg::DELAY_LONG;
            o_src_reserved <= 1'b0;
        end else if (in_reset) begin
            o_cfg <= dec_cfg;
            o_reset_delay <= dec_delay;
            o_src_reserved <= dec_src_res;
        end
    end

    // ------------------------------------------------------------
    // effects on watchdog, protection, clocks and pads
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_halt_reset_req <= 1'b0;
            o_watchdog_hw_on <= 1'b0;
            o_protect_on <= 1'b0;
            o_flash_write_block <= 1'b0;
            o_doubler_on <= 1'b0;
            o_pad_pullup_lock <= 1'b1;
        end else if (!in_reset) begin
            o_halt_reset_req <= i_halt_entry && i_watchdog_active
                && o_cfg.halt_watchdog_reset_sel;
            o_watchdog_hw_on <= !o_cfg.watchdog_type_sel;
            o_protect_on <= !o_cfg.readout_protect;
            o_flash_write_block <= !o_cfg.readout_protect;
            o_doubler_on <= !o_cfg.freq_doubler_off;
            o_pad_pullup_lock <= |i_unbonded_port;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_hrdata <= 32'h0000_0000;
        end else if (ap_valid && !i_hwrite) begin
            case (i_haddr)
                cfg_pkg::ADDR_BYTES: o_hrdata <= prog_mode
                    ? {16'h0000, nv_byte1, nv_byte0} : 32'h0000_0000;
                cfg_pkg::ADDR_DECODE: o_hrdata <= {21'h00_0000, o_cfg};
                cfg_pkg::ADDR_STATUS: o_hrdata <= {14'h0000, dec_is_res,
                    o_reset_delay, state};
                cfg_pkg::ADDR_CTRL: o_hrdata <= {31'h00000000, prog_mode};
                default: o_hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : option_byte_config_decode

// ---- tb/cfg_checker_properties.sv ----
// port checker for the configuration decoder
// assumes bind onto option_byte_config_decode
`timescale 1ns/100ps
module cfg_checker (
    input wire logic i_mclk, // clock
    input wire logic i_rstn, // reset
    input wire logic i_halt_entry, // halt
    input wire logic i_watchdog_active, // wdg on
    input wire cfg_pkg::cfg_s o_cfg, // settings
    input wire logic [12:0] o_reset_delay, // delay
    input wire logic o_halt_reset_req, // halt rst
    input wire logic o_protect_on, // protect
    input wire logic o_flash_write_block, // wr block
    input wire logic o_user_mem_wipe, // wipe
    input wire logic o_doubler_on, // doubler
    input wire logic o_src_reserved // bad src
);
    // ----
    // cycles since reset release, saturating
    // ----
    logic [1:0] up;
    logic trig;
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end
    assign trig = i_halt_entry && i_watchdog_active
        && o_cfg.halt_watchdog_reset_sel;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    halt_rst_set_a: assert property (trig |=> o_halt_reset_req)
        else $error("halt reset missing");
    halt_rst_clr_a: assert property (!trig |=> !o_halt_reset_req)
        else $error("halt reset spurious");
    cfg_hold_a: assert property (up == 2'h3 |-> $stable(o_cfg))
        else $error("settings moved");
    delay_sel_a: assert property (up[1] |-> o_reset_delay ==
        (o_cfg.reset_delay_sel ? cfg_pkg::DELAY_SHORT : cfg_pkg::DELAY_LONG))
        else $error("delay wrong");
    protect_out_a: assert property (up[1] |->
        o_protect_on == !o_cfg.readout_protect
        && o_flash_write_block == !o_cfg.readout_protect)
        else $error("protection wrong");
    doubler_out_a: assert property (up[1] |->
        o_doubler_on == !o_cfg.freq_doubler_off)
        else $error("doubler wrong");
    src_rsvd_a: assert property (up[1] |-> o_src_reserved ==
        (o_cfg.clock_source_type inside {2'h1, 2'h2}))
        else $error("source flag wrong");
    wipe_pulse_a: assert property (o_user_mem_wipe |=> !o_user_mem_wipe)
        else $error("wipe too long");
    cover property (o_halt_reset_req);
    cover property (o_user_mem_wipe);
    cover property (o_doubler_on);
endmodule : cfg_checker
bind option_byte_config_decode cfg_checker cfg_checker_inst (
    .i_mclk, .i_rstn, .i_halt_entry, .i_watchdog_active, .o_cfg,
    .o_reset_delay, .o_halt_reset_req, .o_protect_on,
    .o_flash_write_block, .o_user_mem_wipe, .o_doubler_on, .o_src_reserved);

// ---- tb/prog_tool_model.sv ----
// programming tool model: single-word ahb-lite master
// assumes xfer is entered just after a rising edge
`timescale 1ns/100ps
module prog_tool_model (
    input wire logic i_mclk, // clock
    input wire logic i_hready, // ready
    input wire logic [31:0] i_hrdata, // rd data
    output logic o_hsel, // select
    output logic [11:0] o_haddr, // address
    output logic [1:0] o_htrans, // trans
    output logic o_hwrite, // write
    output logic [2:0] o_hsize, // size
    output logic [31:0] o_hwdata // wr data
);
    initial begin
        o_hsel = 1'b0;
        o_haddr = 12'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r);
        o_hsel <= 1'b1;
        o_haddr <= a;
        o_htrans <= 2'h2;
        o_hwrite <= w;
        @(posedge i_mclk);
        while (i_hready !== 1'b1) @(posedge i_mclk);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= d;
        @(posedge i_mclk);
        while (i_hready !== 1'b1) @(posedge i_mclk);
        r = i_hrdata;
        // released data must not keep its last value
        o_hwdata <= ~d;
    endtask : xfer
endmodule : prog_tool_model

// ---- tb/test_option_byte_config_decode.sv ----
// bench for the configuration decoder
// assumes the tool model drives the register bus
`timescale 1ns/100ps
module test_option_byte_config_decode;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_halt_entry = 1'b0;
    logic i_watchdog_active = 1'b0;
    logic [2:0] i_unbonded_port = 3'h4;
    logic hsel, hwrite, hready, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, r;
    cfg_pkg::cfg_s cfg;
    logic [12:0] dly;
    logic hreq, hw_on, prot, fblk, wipe, lock, dbl, srsv;
    int error_cnt = 0;
    int total_checks = 0;
    int wipes = 0;
    int n;
    always #4 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (wipe === 1'b1) wipes++;
    option_byte_config_decode option_byte_config_decode_inst (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .i_halt_entry(i_halt_entry), .i_watchdog_active(i_watchdog_active),
        .i_unbonded_port(i_unbonded_port), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .o_cfg(cfg),
        .o_reset_delay(dly), .o_halt_reset_req(hreq),
        .o_watchdog_hw_on(hw_on), .o_protect_on(prot),
        .o_flash_write_block(fblk), .o_user_mem_wipe(wipe),
        .o_pad_pullup_lock(lock), .o_doubler_on(dbl), .o_src_reserved(srsv));
    prog_tool_model prog_tool_model_inst (
        .i_mclk(i_mclk), .i_hready(hready), .i_hrdata(hrdata),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic results;
        if (error_cnt == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        prog_tool_model_inst.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        prog_tool_model_inst.xfer(1'b0, a, 32'h0, r);
    endtask : rd
    task automatic rst(input int k);
        i_rstn <= 1'b0;
        repeat (k - 1) @(posedge i_mclk);
        @(negedge i_mclk);
        chk(lock, 1'b1);
        @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask : rst
    task automatic halt_chk(input logic e);
        @(posedge i_mclk);
        i_halt_entry <= 1'b1;
        i_watchdog_active <= 1'b1;
        @(posedge i_mclk);
        @(negedge i_mclk);
        chk(hreq, e);
        @(posedge i_mclk);
        i_halt_entry <= 1'b0;
    endtask : halt_chk
    initial begin
        rst(16);
        chk(cfg, 11'h76f);
        chk(dly, 13'h0100);
        chk({hw_on, prot, fblk, dbl, srsv, lock}, 6'h03);
        halt_chk(1'b1);
        wr(cfg_pkg::ADDR_BYTES, 32'h8226);
        rd(cfg_pkg::ADDR_BYTES);
        chk(r, 32'h0);
        wr(cfg_pkg::ADDR_CTRL, 32'h1);
        rd(cfg_pkg::ADDR_BYTES);
        chk(r, 32'h6fe7);
        wr(cfg_pkg::ADDR_BYTES, 32'h8226);
        rd(cfg_pkg::ADDR_BYTES);
        chk(r, 32'h8226);
        rd(12'h010);
        chk(r, 32'h0);
        chk({hready, hresp}, 32'h2);
        rd(cfg_pkg::ADDR_DECODE);
        chk(r, 32'h76f);
        rd(cfg_pkg::ADDR_STATUS);
        chk(r, {14'h0000, 1'b1, cfg_pkg::DELAY_SHORT, 4'h1});
        chk(cfg, 11'h76f);
        i_unbonded_port <= 3'h0;
        rst(2);
        chk(cfg, 11'h082);
        chk(dly, 13'h1000);
        chk({hw_on, prot, fblk, dbl, srsv, lock}, 6'h3c);
        halt_chk(1'b0);
        wr(cfg_pkg::ADDR_CTRL, 32'h1);
        wr(cfg_pkg::ADDR_CTRL, 32'h3);
        for (n = 0; n < 40 && r !== 32'hffff; n++) rd(cfg_pkg::ADDR_BYTES);
        chk(r, 32'hffff);
        chk(32'(wipes), 32'h1);
        rst(2);
        chk(cfg, 11'h7ff);
        chk(dly, 13'h0100);
        chk({hw_on, prot, fblk, dbl, srsv}, 5'h0);
        @(posedge i_mclk);
        wr(cfg_pkg::ADDR_CTRL, 32'h1);
        wr(cfg_pkg::ADDR_BYTES, 32'h6fe7);
        wr(cfg_pkg::ADDR_CTRL, 32'h3);
        for (n = 0; n < 40 && r !== 32'hffff; n++) rd(cfg_pkg::ADDR_BYTES);
        chk(r, 32'hffff);
        chk(32'(wipes), 32'h1);
        results();
    end
    initial begin
        #200000;
        error_cnt++;
        results();
    end
endmodule : test_option_byte_config_decode
